// ==== logic/pcix_pm_capability_regs.svh ====
// Offsets, field positions, reset values and fixed codes of the capability registers
`ifndef PCIX_PM_CAPABILITY_REGS_SVH
`define PCIX_PM_CAPABILITY_REGS_SVH

// Dword byte addresses in configuration space
`define PXP_PMCSR_OFS 8'hc4
`define PXP_CAPHDR_OFS 8'he0
`define PXP_SR_OFS 8'he4

// Printed offsets of the byte-wide and half-word registers
`define PXP_CAPID_BYTE_OFS 8'he0
`define PXP_NXTP_BYTE_OFS 8'he1
`define PXP_CMD_BYTE_OFS 8'he2

// Fixed and reset values
`define PXP_CAPID_VAL 8'h07
`define PXP_NXTP_RST 8'h00
`define PXP_NXTP_VITAL 8'hb8
`define PXP_PS_RST 2'h0
`define PXP_PS_D0 2'h0
`define PXP_PS_D1 2'h1
`define PXP_PS_D2 2'h2
`define PXP_PS_D3HOT 2'h3
`define PXP_SPLIT_RST 3'h3
`define PXP_RDCNT_RST 2'h0
`define PXP_DEV_RST 5'h1f
`define PXP_BUS_RST 8'hff
`define PXP_FUNC_NUM 3'h0
`define PXP_RDBYTE_BASE 13'h0200

// Field positions within the 16-bit command register
`define PXP_CMD_DPER_BIT 0
`define PXP_CMD_RELAX_BIT 1
`define PXP_CMD_RDCNT_LSB 2
`define PXP_CMD_SPLIT_LSB 4

// Field positions within the power control/status register
`define PXP_PS_LSB 0
`define PXP_WAKE_EN_BIT 8
`define PXP_WAKE_FLAG_BIT 15

`endif

// ==== logic/pcix_pm_pkg.sv ====
// Types shared by the capability register bank
`default_nettype none

package pcix_pm_pkg;

  // One register access from the configuration agent or local firmware
  typedef struct packed {
    logic wr;
    logic rd;
    logic local_src;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Bus phases seen by the target decoder
  typedef struct packed {
    logic addr_valid;
    logic cfg_write;
    logic idsel;
    logic attr_valid;
    logic [31:0] ad;
  } bus_phase_t;

  // Configuration-hold sequencer
  typedef enum logic [2:0] {
    SEQ_STRAP = 3'b001,
    SEQ_HOLD = 3'b010,
    SEQ_RUN = 3'b100
  } seq_state_t;

  // Whole state of the register bank
  typedef struct packed {
    seq_state_t seq;
    logic [1:0] retry_s1;
    logic [1:0] retry_s2;
    logic [1:0] power_state;
    logic [2:0] split_code;
    logic [1:0] rdcnt_code;
    logic dper_en;
    logic [7:0] next_ptr;
    logic [4:0] dev_num;
    logic [7:0] bus_num;
    logic bus_pend;
    logic [31:0] rdata;
    logic ack;
    logic serr;
    logic retry_t0;
    logic core_boot;
    logic [5:0] split_cnt;
    logic [12:0] rd_bytes;
    logic relax;
  } state_t;

endpackage

`default_nettype wire

// ==== logic/pcix_pm_capability_regs.sv ====
// Power-management and PCI-X capability registers of the translation function
`timescale 1ns/1ps
`default_nettype none
`include "pcix_pm_capability_regs.svh"

// Overview of operation
// - Power state bits 1:0 read current state, write selects 00 D0 to 11 D3hot.
// - Only D0 and D3hot are supported; D2 is not.
// - Wake-event flag bit 15 always reads zero.
// - Wake-event enable bit 8 is read-only zero; writes ignored.
// - Capability identifier byte always returns 07h.
// - Next pointer resets to 00h; local firmware may set B8h for vital product data.
// - Strap at power-good retries Type 0 configuration until pointer set; boot strap too.
// - Command bits 6:4 reset 011, limit split transactions 1,2,3,4,8,12,16,32.
// - Command bits 3:2 reset 00, select burst read byte count 512 to 4096.
// - Every addressing configuration write captures AD[15:11] as device number.
// - Device number resets 11111 and follows the addressing configuration write.
// - Bus number resets FFh, loaded from attribute phase AD[7:0], PCI-X only.
// - Addressed means config write, IDSEL, AD[1:0]=00, AD[10:8]=function number.
// - Function number is fixed 000 and forms requester ID with bus and device.
// - Split completion discarded bit 18 is never set; write-one-clear.
// - Status bit 17 reads one: 133 MHz capable.
// - Status bit 16 reads one: 64-bit bus.
module pcix_pm_capability_regs (
  input wire logic ref_clk_in,                       // 200 MHz clock
  input wire logic rst_in,                           // Synchronous reset, high
  input wire pcix_pm_pkg::cfg_req_t cfg_req_in,      // Register access request
  output logic [31:0] cfg_rdata_out,                 // Read data
  output logic cfg_ack_out,                          // Access done pulse
  input wire pcix_pm_pkg::bus_phase_t bus_phase_in,  // Decoded bus phases
  input wire logic pcix_mode_in,                     // Bus runs in PCI-X mode
  input wire logic serr_enable_in,                   // System error reporting on
  input wire logic master_dpe_set_in,                // Master parity flag set pulse
  input wire logic retry_strap_in,                   // Retry Type 0 strap pin
  input wire logic boot_strap_in,                    // Core boot strap pin
  output logic [1:0] power_state_out,                // Current power state
  output logic [5:0] max_split_out,                  // Split transaction limit
  output logic [12:0] max_read_bytes_out,            // Burst read byte limit
  output logic dper_enable_out,                      // Parity recovery enabled
  output logic relaxed_order_out,                    // Relaxed ordering attribute
  output logic serr_out,                             // System error pulse
  output logic [15:0] requester_id_out,              // Bus, device, function
  output logic [7:0] next_ptr_out,                   // Next capability pointer
  output logic retry_type0_out,                      // Retry Type 0 config cycles
  output logic core_boot_out                         // Core allowed to boot
);

  // Reset image of the whole state
  localparam pcix_pm_pkg::state_t ST_RESET = '{
    seq: pcix_pm_pkg::SEQ_STRAP,
    retry_s1: 2'h0,
    retry_s2: 2'h0,
    power_state: `PXP_PS_RST,
    split_code: `PXP_SPLIT_RST,
    rdcnt_code: `PXP_RDCNT_RST,
    dper_en: 1'b0,
    next_ptr: `PXP_NXTP_RST,
    dev_num: `PXP_DEV_RST,
    bus_num: `PXP_BUS_RST,
    bus_pend: 1'b0,
    rdata: 32'h0000_0000,
    ack: 1'b0,
    serr: 1'b0,
    retry_t0: 1'b0,
    core_boot: 1'b0,
    split_cnt: 6'h04,
    rd_bytes: `PXP_RDBYTE_BASE,
    relax: 1'b0
  };

  pcix_pm_pkg::state_t st_reg;
  pcix_pm_pkg::state_t st_next;
  logic [15:0] pmcsr_rd;
  logic [15:0] cmd_rd;
  logic [31:0] caphdr_rd;
  logic [31:0] sr_rd;
  logic addressed;
  logic wr_pmcsr;
  logic wr_caphdr;
  logic rd_hit;

  // Split transaction code to count
  function automatic logic [5:0] split_decode(input logic [2:0] code);
    logic [5:0] cnt;
    cnt = 6'h01;
    case (code)
      3'h0: cnt = 6'h01;
      3'h1: cnt = 6'h02;
      3'h2: cnt = 6'h03;
      3'h3: cnt = 6'h04;
      3'h4: cnt = 6'h08;
      3'h5: cnt = 6'h0c;
      3'h6: cnt = 6'h10;
      3'h7: cnt = 6'h20;
      default: cnt = 6'h01;
    endcase
    return cnt;
  endfunction

  // Read images of the three dwords
  always_comb begin
    pmcsr_rd = 16'h0000;
    pmcsr_rd[`PXP_PS_LSB +: 2] = st_reg.power_state;
    pmcsr_rd[`PXP_WAKE_FLAG_BIT] = 1'b0;
    pmcsr_rd[`PXP_WAKE_EN_BIT] = 1'b0;
    cmd_rd = 16'h0000;
    cmd_rd[`PXP_CMD_SPLIT_LSB +: 3] = st_reg.split_code;
    cmd_rd[`PXP_CMD_RDCNT_LSB +: 2] = st_reg.rdcnt_code;
    cmd_rd[`PXP_CMD_RELAX_BIT] = 1'b0;
    cmd_rd[`PXP_CMD_DPER_BIT] = st_reg.dper_en;
    caphdr_rd = {cmd_rd, st_reg.next_ptr, `PXP_CAPID_VAL};
    sr_rd = 32'h0000_0000;
    sr_rd[17] = 1'b1;
    sr_rd[16] = 1'b1;
    sr_rd[15:8] = st_reg.bus_num;
    sr_rd[7:3] = st_reg.dev_num;
    sr_rd[2:0] = `PXP_FUNC_NUM;
  end

  // Target decode of the address phase
  always_comb begin
    addressed = bus_phase_in.addr_valid &&
                bus_phase_in.cfg_write &&
                bus_phase_in.idsel &&
                (bus_phase_in.ad[1:0] == 2'h0) &&
                (bus_phase_in.ad[10:8] == `PXP_FUNC_NUM);
  end

  // Register access decode
  always_comb begin
    wr_pmcsr = cfg_req_in.wr && (cfg_req_in.addr == `PXP_PMCSR_OFS);
    wr_caphdr = cfg_req_in.wr && (cfg_req_in.addr == `PXP_CAPHDR_OFS);
    rd_hit = cfg_req_in.rd;
  end

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.serr = 1'b0;
    // Strap pins pass two flops first
    st_next.retry_s1 = {boot_strap_in, retry_strap_in};
    st_next.retry_s2 = st_reg.retry_s1;

    case (st_reg.seq)
      pcix_pm_pkg::SEQ_STRAP: begin
        st_next.core_boot = st_reg.retry_s2[1];
        if (st_reg.retry_s2[0]) begin
          st_next.retry_t0 = 1'b1;
          st_next.seq = pcix_pm_pkg::SEQ_HOLD;
        end else begin
          st_next.retry_t0 = 1'b0;
          st_next.seq = pcix_pm_pkg::SEQ_RUN;
        end
      end
      pcix_pm_pkg::SEQ_HOLD: begin
        if (wr_caphdr && cfg_req_in.local_src && cfg_req_in.be[1]) begin
          st_next.retry_t0 = 1'b0;
          st_next.seq = pcix_pm_pkg::SEQ_RUN;
        end
      end
      pcix_pm_pkg::SEQ_RUN: begin
        st_next.retry_t0 = 1'b0;
      end
      default: begin
        st_next.retry_t0 = 1'b0;
        st_next.seq = pcix_pm_pkg::SEQ_RUN;
      end
    endcase

    // Power state write
    if (wr_pmcsr && cfg_req_in.be[0]) begin
      if ((cfg_req_in.wdata[1:0] == `PXP_PS_D0) ||
          (cfg_req_in.wdata[1:0] == `PXP_PS_D3HOT)) begin
        st_next.power_state = cfg_req_in.wdata[1:0];
      end
      // D1 and D2 keep old state
    end

    // Next pointer write, local firmware only
    if (wr_caphdr && cfg_req_in.be[1] && cfg_req_in.local_src) begin
      st_next.next_ptr = cfg_req_in.wdata[15:8];
    end

    // Command register low byte
    if (wr_caphdr && cfg_req_in.be[2]) begin
      st_next.split_code = cfg_req_in.wdata[16 + `PXP_CMD_SPLIT_LSB +: 3];
      st_next.rdcnt_code = cfg_req_in.wdata[16 + `PXP_CMD_RDCNT_LSB +: 2];
      st_next.dper_en = cfg_req_in.wdata[16 + `PXP_CMD_DPER_BIT];
    end

    // Decoded limits follow the stored codes
    st_next.split_cnt = split_decode(st_next.split_code);
    st_next.rd_bytes = `PXP_RDBYTE_BASE << st_next.rdcnt_code;
    st_next.relax = 1'b0;

    if (addressed) begin
      st_next.dev_num = bus_phase_in.ad[15:11];
      st_next.bus_pend = pcix_mode_in;
    end else if (bus_phase_in.attr_valid) begin
      st_next.bus_pend = 1'b0;
    end
    if (st_reg.bus_pend && bus_phase_in.attr_valid && pcix_mode_in) begin
      st_next.bus_num = bus_phase_in.ad[7:0];
    end

    if (master_dpe_set_in && pcix_mode_in && serr_enable_in && !st_reg.dper_en) begin
      st_next.serr = 1'b1;
    end

    // Access answer one cycle later
    if (cfg_req_in.rd || cfg_req_in.wr) begin
      st_next.ack = 1'b1;
    end
    if (rd_hit) begin
      case (cfg_req_in.addr)
        `PXP_PMCSR_OFS: st_next.rdata = {16'h0000, pmcsr_rd};
        `PXP_CAPHDR_OFS: st_next.rdata = caphdr_rd;
        `PXP_SR_OFS: st_next.rdata = sr_rd;
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg <= ST_RESET;
      // Strap synchronisers keep shifting in reset, so release sees settled straps
      st_reg.retry_s1 <= st_next.retry_s1;
      st_reg.retry_s2 <= st_next.retry_s2;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign cfg_rdata_out = st_reg.rdata;
  assign cfg_ack_out = st_reg.ack;
  assign power_state_out = st_reg.power_state;
  assign max_split_out = st_reg.split_cnt;
  assign max_read_bytes_out = st_reg.rd_bytes;
  assign dper_enable_out = st_reg.dper_en;
  assign relaxed_order_out = st_reg.relax;
  assign serr_out = st_reg.serr;
  assign requester_id_out = {st_reg.bus_num, st_reg.dev_num, `PXP_FUNC_NUM};
  assign next_ptr_out = st_reg.next_ptr;
  assign retry_type0_out = st_reg.retry_t0;
  assign core_boot_out = st_reg.core_boot;

endmodule

`default_nettype wire

// ==== verif/pcix_pm_capability_regs_asserts.sv ====
// Concurrent checks on the ports of the capability register bank
`timescale 1ns/1ps
`default_nettype none
module pcix_pm_capability_regs_asserts (
  input wire logic ref_clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire pcix_pm_pkg::cfg_req_t cfg_req_in, // Request
  input wire logic [31:0] cfg_rdata_out, // Read data
  input wire logic cfg_ack_out, // Done pulse
  input wire pcix_pm_pkg::bus_phase_t bus_phase_in, // Bus phases
  input wire logic pcix_mode_in, // PCI-X mode
  input wire logic serr_enable_in, // SERR enable
  input wire logic master_dpe_set_in, // Parity flag pulse
  input wire logic [1:0] power_state_out, // Power state
  input wire logic [5:0] max_split_out, // Split limit
  input wire logic dper_enable_out, // Recovery enable
  input wire logic relaxed_order_out, // Relaxed ordering
  input wire logic serr_out, // SERR pulse
  input wire logic [15:0] requester_id_out // Requester ID
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Read of one dword and its answer
  sequence s_rd(a);
    cfg_req_in.rd && cfg_req_in.addr == a ##1 cfg_ack_out;
  endsequence
  // Address phase of a write that addresses this function
  sequence s_addr_wr;
    bus_phase_in.addr_valid && bus_phase_in.cfg_write && bus_phase_in.idsel &&
      bus_phase_in.ad[1:0] == 2'h0 && bus_phase_in.ad[10:8] == 3'h0;
  endsequence
  wake_bits_zero_a: assert property (s_rd(8'hc4) |-> !cfg_rdata_out[15] && !cfg_rdata_out[8])
    else $error("wake bits read nonzero");
  power_legal_a: assert property (power_state_out == 2'h0 || power_state_out == 2'h3)
    else $error("unsupported power state");
  power_hold_a: assert property (cfg_req_in.wr && cfg_req_in.addr == 8'hc4 && cfg_req_in.be[0]
    && cfg_req_in.wdata[1] != cfg_req_in.wdata[0] |=> $stable(power_state_out))
    else $error("power state took D1 or D2");
  capid_fixed_a: assert property (s_rd(8'he0) |-> cfg_rdata_out[7:0] == 8'h07)
    else $error("capability id wrong");
  status_fixed_a: assert property (s_rd(8'he4) |-> cfg_rdata_out[18:16] == 3'h3
    && cfg_rdata_out[2:0] == 3'h0) else $error("status fixed bits wrong");
  relax_zero_a: assert property (!relaxed_order_out)
    else $error("relaxed ordering set");
  serr_raise_a: assert property (master_dpe_set_in && pcix_mode_in && serr_enable_in
    && !dper_enable_out |=> serr_out) else $error("no SERR pulse");
  dev_capture_a: assert property (s_addr_wr |=> requester_id_out[7:3] == $past(bus_phase_in.ad[15:11]))
    else $error("device number not captured");
  split_code_a: assert property (max_split_out inside {6'd1, 6'd2, 6'd3, 6'd4, 6'd8, 6'd12, 6'd16, 6'd32})
    else $error("split limit off table");
  bus_conv_a: assert property (!pcix_mode_in ##1 !pcix_mode_in |-> $stable(requester_id_out[15:8]))
    else $error("bus number moved in conventional mode");
endmodule
`default_nettype wire

// ==== verif/pcix_host_agent.sv ====
// Host configuration agent model driving address and attribute phases
`timescale 1ns/1ps
`default_nettype none
module pcix_host_agent (
  input wire logic ref_clk_in, // Clock
  output var pcix_pm_pkg::bus_phase_t phase_out // Bus phases
);
  initial phase_out = '0;
  task automatic cfg_wr(input logic x_mode, input logic sel, input logic [1:0] typ,
                        input logic [2:0] fn, input logic [4:0] dev, input logic [7:0] bus);
    @(posedge ref_clk_in);
    phase_out <= '{1'b1, 1'b1, sel, 1'b0, {16'h0, dev, fn, 6'h39, typ}};
    @(posedge ref_clk_in);
    phase_out <= '{1'b0, 1'b0, 1'b0, x_mode, {24'h0, bus}};
    @(posedge ref_clk_in);
    // Released bus shows the inverse of its last value
    phase_out <= '{1'b0, 1'b0, 1'b0, 1'b0, ~{24'h0, bus}};
  endtask
endmodule
`default_nettype wire

// ==== verif/pcix_pm_capability_regs_tb.sv ====
// Self-checking bench for the capability register bank
`timescale 1ns/1ps
`default_nettype none
module pcix_pm_capability_regs_tb;
  logic ref_clk_in, rst_in, cfg_ack_out, pcix_mode_in, serr_enable_in, master_dpe_set_in;
  logic retry_strap_in, boot_strap_in, dper_enable_out, relaxed_order_out, serr_out;
  logic retry_type0_out, core_boot_out;
  pcix_pm_pkg::cfg_req_t cfg_req_in;
  pcix_pm_pkg::bus_phase_t bus_phase_in;
  logic [31:0] cfg_rdata_out;
  logic [1:0] power_state_out;
  logic [5:0] max_split_out;
  logic [12:0] max_read_bytes_out;
  logic [15:0] requester_id_out;
  logic [7:0] next_ptr_out, bus;
  logic [4:0] dev;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int err_count = 0, num_checks = 0;
  integer seed = 77;
  int split_tab[8] = '{1, 2, 3, 4, 8, 12, 16, 32};
  pcix_pm_capability_regs u_pcix_pm_capability_regs (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_req_in(cfg_req_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out), .bus_phase_in(bus_phase_in),
    .pcix_mode_in(pcix_mode_in), .serr_enable_in(serr_enable_in),
    .master_dpe_set_in(master_dpe_set_in), .retry_strap_in(retry_strap_in),
    .boot_strap_in(boot_strap_in), .power_state_out(power_state_out),
    .max_split_out(max_split_out), .max_read_bytes_out(max_read_bytes_out),
    .dper_enable_out(dper_enable_out), .relaxed_order_out(relaxed_order_out),
    .serr_out(serr_out), .requester_id_out(requester_id_out), .next_ptr_out(next_ptr_out),
    .retry_type0_out(retry_type0_out), .core_boot_out(core_boot_out)
  );
  pcix_host_agent u_pcix_host_agent (.ref_clk_in(ref_clk_in), .phase_out(bus_phase_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One register access; each access notes its expected answer
  task automatic acc(input logic w, input logic loc, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic [31:0] x);
    @(posedge ref_clk_in);
    cfg_req_in <= '{w, !w, loc, a, be, d};
    exp_q.push_back({!w, x});
    @(posedge ref_clk_in);
    cfg_req_in.wr <= 1'b0;
    cfg_req_in.rd <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, 1'b0, a, 4'hf, 32'h0, x);
  endtask
  task automatic dpe(input logic x);
    @(posedge ref_clk_in);
    master_dpe_set_in <= 1'b1;
    @(posedge ref_clk_in);
    master_dpe_set_in <= 1'b0;
    #1 check({31'h0, serr_out}, {31'h0, x});
  endtask
  // Answer watcher: every done pulse takes the oldest note
  always @(posedge ref_clk_in) begin
    if (cfg_ack_out === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        if (e[32]) check(cfg_rdata_out, e[31:0]);
      end
    end
  end
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    err_count++;
    final_report();
  end
  initial begin
    {rst_in, retry_strap_in, boot_strap_in} = 3'h7;
    cfg_req_in = '0;
    {pcix_mode_in, serr_enable_in, master_dpe_set_in} = 3'h0;
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(8'hc4, 32'h0);
    check({31'h0, retry_type0_out}, 32'h1);
    check({31'h0, core_boot_out}, 32'h1);
    acc(1'b1, 1'b0, 8'hc4, 4'h3, 32'h8103, 32'h0);
    rd(8'hc4, 32'h3);
    for (int i = 1; i < 3; i++) begin
      acc(1'b1, 1'b0, 8'hc4, 4'h1, i, 32'h0);
      rd(8'hc4, 32'h3);
    end
    acc(1'b1, 1'b0, 8'hc4, 4'h1, 32'h0, 32'h0);
    rd(8'hc4, 32'h0);
    rd(8'he0, 32'h0030_0007);
    for (logic [3:0] i = 0; i < 8; i++) begin
      acc(1'b1, 1'b0, 8'he0, 4'h4, {9'h0, i[2:0], i[1:0], 2'h2, 16'h0}, 32'h0);
      check({26'h0, max_split_out}, split_tab[i]);
      check({19'h0, max_read_bytes_out}, 32'd512 << i[1:0]);
      rd(8'he0, {9'h0, i[2:0], i[1:0], 2'h0, 16'h0007});
    end
    @(posedge ref_clk_in) {pcix_mode_in, serr_enable_in} <= 2'h3;
    acc(1'b1, 1'b0, 8'he0, 4'h4, 32'h0001_0000, 32'h0);
    check({31'h0, dper_enable_out}, 32'h1);
    dpe(1'b0);
    acc(1'b1, 1'b0, 8'he0, 4'h4, 32'h0, 32'h0);
    dpe(1'b1);
    @(posedge ref_clk_in) serr_enable_in <= 1'b0;
    dpe(1'b0);
    // only local firmware moves the pointer, to B8h
    acc(1'b1, 1'b0, 8'he0, 4'h2, 32'h0000_b800, 32'h0);
    check({24'h0, next_ptr_out}, 32'h0);
    check({31'h0, retry_type0_out}, 32'h1);
    acc(1'b1, 1'b1, 8'he0, 4'h2, 32'h0000_b800, 32'h0);
    check({24'h0, next_ptr_out}, 32'hb8);
    check({31'h0, retry_type0_out}, 32'h0);
    check({31'h0, core_boot_out}, 32'h1);
    rd(8'h40, 32'h0);
    rd(8'he4, 32'h0003_fff8);
    acc(1'b1, 1'b0, 8'he4, 4'hf, 32'hffff_ffff, 32'h0);
    rd(8'he4, 32'h0003_fff8);
    dev = 5'($random(seed));
    bus = 8'($random(seed));
    u_pcix_host_agent.cfg_wr(1'b1, 1'b1, 2'h0, 3'h0, dev, bus);
    rd(8'he4, {16'h0003, bus, dev, 3'h0});
    for (int j = 0; j < 3; j++) begin
      u_pcix_host_agent.cfg_wr(1'b1, j != 0, {1'b0, j == 1}, {2'h0, j == 2}, ~dev, ~bus);
      #1 check({16'h0, requester_id_out}, {16'h0, bus, dev, 3'h0});
    end
    @(posedge ref_clk_in) pcix_mode_in <= 1'b0;
    u_pcix_host_agent.cfg_wr(1'b0, 1'b1, 2'h0, 3'h0, 5'h0, ~bus);
    rd(8'he4, {16'h0003, bus, 8'h0});
    repeat (3) @(posedge ref_clk_in);
    final_report();
  end
endmodule
bind pcix_pm_capability_regs pcix_pm_capability_regs_asserts u_pcix_pm_capability_regs_asserts (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_req_in(cfg_req_in),
  .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out), .bus_phase_in(bus_phase_in),
  .pcix_mode_in(pcix_mode_in), .serr_enable_in(serr_enable_in),
  .master_dpe_set_in(master_dpe_set_in), .power_state_out(power_state_out),
  .max_split_out(max_split_out), .dper_enable_out(dper_enable_out),
  .relaxed_order_out(relaxed_order_out), .serr_out(serr_out),
  .requester_id_out(requester_id_out)
);
`default_nettype wire
